/* core/dma_defs.svh */
// register offsets, field positions and reset values of the dma unit
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH

// byte offsets inside one 64-byte channel window
`define DMA_OFF_MAR      6'h00
`define DMA_OFF_PSR      6'h04
`define DMA_OFF_TCR      6'h08
`define DMA_OFF_MEMORY_POINTER_RELOAD     6'h0c
`define DMA_OFF_COUNT_RELOAD     6'h10
`define DMA_OFF_CR       6'h14
`define DMA_OFF_MR       6'h18
`define DMA_OFF_SR       6'h1c
`define DMA_OFF_IER      6'h20
`define DMA_OFF_IDR      6'h24
`define DMA_OFF_IMR      6'h28
`define DMA_OFF_ISR      6'h2c

// address bits below the channel number (stride 0x040)
`define DMA_WIN_BITS     6

// channel_control bits
`define DMA_TRANSFER_ENABLE_BIT       0
`define DMA_TRANSFER_DISABLE_BIT      1
`define DMA_ERROR_CLEAR_BIT      8

// irq_mask / irq_status bits
`define DMA_IRQ_RCZ      0
`define DMA_IRQ_TRC      1
`define DMA_IRQ_TERR     2

// reset values
`define DMA_RST_WORD     32'h0000_0000
`define DMA_RST_COUNT    16'h0000
`define DMA_RST_PSR      8'h00

`endif

/* core/dma_pkg.sv */
// types shared by the dma unit and its users
package dma_pkg;

  // transfer_size_field encoding
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2,
    SZ_RSVD = 2'h3
  } xfer_size_t;

  // memory-side request
  typedef struct packed {
    logic        req;
    logic        we;
    xfer_size_t  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_cmd_t;

  // memory-side answer
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } mem_rsp_t;

  // peripheral holding-register access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } per_cmd_t;

endpackage

/* core/peripheral_dma_unit.sv */
// multi-channel peripheral dma unit with classic wishbone registers
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "dma_defs.svh"

module peripheral_dma_unit #(
  parameter int         N_CH    = 4,
  parameter int         PID_W   = 4,
  parameter int         ADR_W   = 12,
  parameter logic [7:0] PSR_RST = `DMA_RST_PSR
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [2**(PID_W-1)-1:0] periph_req,
  output logic      [2**(PID_W-1)-1:0] periph_ack,
  output dma_pkg::per_cmd_t         per_o,
  input  wire logic [31:0]          per_rdata,
  output dma_pkg::mem_cmd_t         mem_o,
  input  wire dma_pkg::mem_rsp_t    mem_i,
  output logic      [N_CH-1:0]      irq
);
  import dma_pkg::*;

  localparam int N_PER = 2**(PID_W-1);
  localparam int CH_W  = (N_CH > 1) ? $clog2(N_CH) : 1;
  localparam int HS_W  = (PID_W > 1) ? PID_W-1 : 1;

  typedef enum {ST_IDLE, ST_PER_RD, ST_MEM, ST_PER_WR} eng_state_t;

  // per-channel register state
  logic [31:0]      mar_q  [N_CH];
  logic [31:0]      memory_pointer_reload_q [N_CH];
  logic [15:0]      tcr_q  [N_CH];
  logic [15:0]      count_reload_q [N_CH];
  logic [PID_W-1:0] psr_q  [N_CH];
  xfer_size_t       size_q [N_CH];
  logic [2:0]       imr_q  [N_CH];
  logic [31:0]      rd_ch  [N_CH];
  logic [N_CH-1:0]  en_q;
  logic [N_CH-1:0]  terr_q;
  logic [N_CH-1:0]  elig;

  // bus side
  logic                  wb_ack_q;
  logic [31:0]           wb_dat_q;
  logic                  acc;
  logic                  wr;
  logic                  ch_ok;
  logic [ADR_W-7:0]      ch_sel;
  logic [5:0]            off;
  logic [31:0]           wmask;
  logic [31:0]           wcmd;

  // engine
  eng_state_t            st_q;
  logic [CH_W-1:0]       gnt_q;
  logic                  dir_q;
  logic [N_PER-1:0]      pack_q;
  per_cmd_t              per_q;
  mem_cmd_t              mem_q;
  logic [N_CH-1:0]       irq_q;
  logic                  gnt_any;
  logic [CH_W-1:0]       gnt_idx;
  logic                  fin;
  logic                  err_now;

  // byte-lane merge for read/write registers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // peripheral word with unused high bits forced to zero
  function automatic logic [31:0] zext(input logic [31:0] d,
                                       input xfer_size_t sz);
    case (sz)
      SZ_HALF: zext = {16'h0000, d[15:0]};
      SZ_WORD: zext = d;
      default: zext = {24'h00_0000, d[7:0]};
    endcase
  endfunction

  // pointer step per item
  function automatic logic [31:0] incr(input xfer_size_t sz);
    case (sz)
      SZ_HALF: incr = 32'h0000_0002;
      SZ_WORD: incr = 32'h0000_0004;
      default: incr = 32'h0000_0001;
    endcase
  endfunction

  // handshake index carried in the low identity bits
  function automatic logic [HS_W-1:0] hs_of(input logic [PID_W-1:0] p);
    hs_of = p[HS_W-1:0];
  endfunction

  // address decode of the channel window
  assign acc    = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  assign ch_sel = wb_adr_i[ADR_W-1:`DMA_WIN_BITS];
  assign off    = {wb_adr_i[5:2], 2'b00};
  assign ch_ok  = 32'(ch_sel) < 32'(N_CH);
  assign wr     = acc & wb_we_i & ch_ok;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wcmd   = wb_dat_i & wmask;

  // item completion and error seen by the channels
  assign fin     = ((st_q == ST_MEM) & mem_i.ack & ~mem_i.err & ~dir_q)
                 | (st_q == ST_PER_WR);
  assign err_now = (st_q == ST_MEM) & mem_i.err;

  genvar c;
  generate
    for (c = 0; c < N_CH; c++) begin : g_ch
      logic        wr_c;
      logic        done_c;
      logic        err_c;
      logic [15:0] tcr_dec;
      logic [31:0] tcr_w;
      logic [31:0] count_reload_w;
      logic        reload_zero_flag;
      logic        transfer_finished_flag;
      logic [2:0]  irq_status;

      assign wr_c    = wr & (32'(ch_sel) == c);
      assign done_c  = fin & (32'(gnt_q) == c);
      assign err_c   = err_now & (32'(gnt_q) == c);
      assign tcr_dec = tcr_q[c] - 16'h0001;
      assign tcr_w   = merge({16'h0000, tcr_q[c]}, wb_dat_i, wmask);
      assign count_reload_w  = merge({16'h0000, count_reload_q[c]}, wb_dat_i, wmask);

      // status flags derived from the counters
      assign reload_zero_flag = (count_reload_q[c] == 16'h0000);
      assign transfer_finished_flag = (tcr_q[c] == 16'h0000) & reload_zero_flag;
      assign irq_status = {terr_q[c], transfer_finished_flag, reload_zero_flag};

      // channel may compete while enabled, clean and counting
      assign elig[c] = en_q[c] & ~terr_q[c]
                     & (tcr_q[c] != 16'h0000)
                     & periph_req[hs_of(psr_q[c])];

      // pointer, count and reload registers
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          mar_q[c]  <= `DMA_RST_WORD;
          memory_pointer_reload_q[c] <= `DMA_RST_WORD;
          tcr_q[c]  <= `DMA_RST_COUNT;
          count_reload_q[c] <= `DMA_RST_COUNT;
        end else begin
          if (done_c) begin
            if (tcr_dec == 16'h0000 && count_reload_q[c] != 16'h0000) begin
              mar_q[c]  <= memory_pointer_reload_q[c];
              tcr_q[c]  <= count_reload_q[c];
              memory_pointer_reload_q[c] <= `DMA_RST_WORD;
              count_reload_q[c] <= `DMA_RST_COUNT;
            end else begin
              mar_q[c] <= mar_q[c] + incr(size_q[c]);
              tcr_q[c] <= tcr_dec;
            end
          end
          if (wr_c && off == `DMA_OFF_MAR) begin
            mar_q[c] <= merge(mar_q[c], wb_dat_i, wmask);
          end
          if (wr_c && off == `DMA_OFF_TCR) begin
            tcr_q[c] <= tcr_w[15:0];
          end
          if (wr_c && off == `DMA_OFF_MEMORY_POINTER_RELOAD) begin
            memory_pointer_reload_q[c] <= merge(memory_pointer_reload_q[c], wb_dat_i, wmask);
          end
          if (wr_c && off == `DMA_OFF_COUNT_RELOAD) begin
            if (tcr_q[c] == 16'h0000 && !done_c) begin
              tcr_q[c]  <= count_reload_w[15:0];
              mar_q[c]  <= memory_pointer_reload_q[c];
              count_reload_q[c] <= `DMA_RST_COUNT;
              memory_pointer_reload_q[c] <= `DMA_RST_WORD;
            end else begin
              count_reload_q[c] <= count_reload_w[15:0];
            end
          end
        end
      end

      // selection, mode, enable, error and mask
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          psr_q[c]  <= PSR_RST[PID_W-1:0];
          size_q[c] <= SZ_BYTE;
          en_q[c]   <= 1'b0;
          terr_q[c] <= 1'b0;
          imr_q[c]  <= 3'h0;
        end else begin
          if (wr_c && off == `DMA_OFF_PSR && wb_sel_i[0]) begin
            psr_q[c] <= wb_dat_i[PID_W-1:0];
          end
          if (wr_c && off == `DMA_OFF_MR && wb_sel_i[0]) begin
            size_q[c] <= xfer_size_t'(wb_dat_i[1:0]);
          end
          if (wr_c && off == `DMA_OFF_CR) begin
            if (wcmd[`DMA_TRANSFER_ENABLE_BIT]) begin
              en_q[c] <= 1'b1;
            end
            if (wcmd[`DMA_TRANSFER_DISABLE_BIT]) begin
              en_q[c] <= 1'b0;
            end
          end
          // a fresh error beats a clear in the same cycle
          terr_q[c] <= err_c | (terr_q[c]
                     & ~(wr_c && off == `DMA_OFF_CR
                         && wcmd[`DMA_ERROR_CLEAR_BIT]));
          if (wr_c && off == `DMA_OFF_IER) begin
            imr_q[c] <= imr_q[c] | wcmd[2:0];
          end
          if (wr_c && off == `DMA_OFF_IDR) begin
            imr_q[c] <= imr_q[c] & ~wcmd[2:0];
          end
        end
      end

      // interrupt line of the channel
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          irq_q[c] <= 1'b0;
        end else begin
          irq_q[c] <= |(irq_status & imr_q[c]);
        end
      end

      // read view of the channel window
      always_comb begin
        case (off)
          `DMA_OFF_MAR:  rd_ch[c] = mar_q[c];
          `DMA_OFF_PSR:  rd_ch[c] = 32'(psr_q[c]);
          `DMA_OFF_TCR:  rd_ch[c] = {16'h0000, tcr_q[c]};
          `DMA_OFF_MEMORY_POINTER_RELOAD: rd_ch[c] = memory_pointer_reload_q[c];
          `DMA_OFF_COUNT_RELOAD: rd_ch[c] = {16'h0000, count_reload_q[c]};
          `DMA_OFF_MR:   rd_ch[c] = {30'h0, size_q[c]};
          `DMA_OFF_SR:   rd_ch[c] = {31'h0, en_q[c]};
          `DMA_OFF_IMR:  rd_ch[c] = {29'h0, imr_q[c]};
          `DMA_OFF_ISR:  rd_ch[c] = {29'h0, irq_status};
          default:       rd_ch[c] = 32'h0000_0000;
        endcase
      end
    end
  endgenerate

  // wishbone answer: one wait state, unmapped reads as zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      wb_ack_q <= acc;
      if (acc && !wb_we_i && ch_ok) begin
        wb_dat_q <= rd_ch[ch_sel[CH_W-1:0]];
      end else begin
        wb_dat_q <= 32'h0000_0000;
      end
    end
  end

  // fixed priority, lowest channel number first
  always_comb begin
    gnt_any = 1'b0;
    gnt_idx = '0;
    for (int i = N_CH-1; i >= 0; i--) begin
      if (elig[i]) begin
        gnt_any = 1'b1;
        gnt_idx = CH_W'(i);
      end
    end
  end

  // transfer engine, one item at a time
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q   <= ST_IDLE;
      gnt_q  <= '0;
      dir_q  <= 1'b0;
      pack_q <= '0;
      per_q  <= '0;
      mem_q  <= '0;
    end else begin
      pack_q   <= '0;
      per_q.rd <= 1'b0;
      per_q.wr <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (gnt_any) begin
            gnt_q  <= gnt_idx;
            dir_q  <= psr_q[gnt_idx][PID_W-1];
            pack_q[hs_of(psr_q[gnt_idx])] <= 1'b1;
            per_q.addr <= 8'(psr_q[gnt_idx]);
            if (psr_q[gnt_idx][PID_W-1]) begin
              mem_q.req   <= 1'b1;
              mem_q.we    <= 1'b0;
              mem_q.size  <= size_q[gnt_idx];
              mem_q.addr  <= mar_q[gnt_idx];
              mem_q.wdata <= 32'h0000_0000;
              st_q        <= ST_MEM;
            end else begin
              per_q.rd <= 1'b1;
              st_q     <= ST_PER_RD;
            end
          end
        end
        ST_PER_RD: begin
          mem_q.req   <= 1'b1;
          mem_q.we    <= 1'b1;
          mem_q.size  <= size_q[gnt_q];
          mem_q.addr  <= mar_q[gnt_q];
          mem_q.wdata <= zext(per_rdata, size_q[gnt_q])
                         << {mar_q[gnt_q][1:0], 3'b000};
          st_q        <= ST_MEM;
        end
        ST_MEM: begin
          if (mem_i.ack || mem_i.err) begin
            mem_q.req <= 1'b0;
            mem_q.we  <= 1'b0;
            if (mem_i.err) begin
              st_q <= ST_IDLE;
            end else if (dir_q) begin
              per_q.wr    <= 1'b1;
              per_q.wdata <= zext(mem_i.rdata
                             >> {mem_q.addr[1:0], 3'b000}, mem_q.size);
              st_q        <= ST_PER_WR;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_PER_WR: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // every output straight from a flip-flop
  assign wb_ack_o   = wb_ack_q;
  assign wb_dat_o   = wb_dat_q;
  assign periph_ack = pack_q;
  assign per_o      = per_q;
  assign mem_o      = mem_q;
  assign irq        = irq_q;

endmodule // peripheral_dma_unit

/* verif/dma_far_model.sv */
// far side of the dma unit: peripherals and a memory slave
`timescale 1ns/100ps
module dma_far_model
  import dma_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [7:0]        want,
  input  wire logic [1:0]        lag,
  output logic      [7:0]        periph_req,
  input  wire logic [7:0]        periph_ack,
  input  wire dma_pkg::per_cmd_t per_o,
  output logic      [31:0]       per_rdata,
  input  wire dma_pkg::mem_cmd_t mem_o,
  output dma_pkg::mem_rsp_t      mem_i,
  output logic      [31:0]       mem_wdata_q,
  output logic      [31:0]       per_wdata_q
);
  logic [1:0]  wait_q;
  logic [31:0] junk_q;

  // holding data shows while the read strobe stands, junk otherwise
  assign per_rdata = per_o.rd ? 32'hdead_beef : junk_q;

  // requests drop for a cycle after each grant, then follow want
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) periph_req <= 8'h00;
    else periph_req <= want & ~periph_ack;
  end

  // junk pattern outside reads, last word written to the peripheral
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      junk_q      <= 32'h0000_0000;
      per_wdata_q <= 32'h0000_0000;
    end else begin
      junk_q <= {junk_q[30:0], ~junk_q[31]};
      if (per_o.wr) per_wdata_q <= per_o.wdata;
    end
  end

  // memory answers after lag cycles; top region faults
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mem_i       <= '0;
      wait_q      <= 2'h0;
      mem_wdata_q <= 32'h0000_0000;
    end else begin
      mem_i.ack   <= 1'b0;
      mem_i.err   <= 1'b0;
      mem_i.rdata <= {mem_i.rdata[30:0], ~mem_i.rdata[31]};
      if (mem_o.req && !mem_i.ack && !mem_i.err) begin
        wait_q <= wait_q + 2'h1;
        if (wait_q == lag) begin
          wait_q <= 2'h0;
          if (mem_o.addr[31:28] == 4'hf) mem_i.err <= 1'b1;
          else begin
            mem_i.ack   <= 1'b1;
            mem_i.rdata <= mem_o.addr ^ 32'h5a5a_5a5a;
            if (mem_o.we) mem_wdata_q <= mem_o.wdata;
          end
        end
      end
    end
  end
endmodule // dma_far_model

/* verif/dma_unit_sva.sv */
// port checker for the dma unit, bound to its top module
`timescale 1ns/100ps
module dma_unit_chk
  import dma_pkg::*;
#(
  parameter int N_CH  = 4,
  parameter int PID_W = 4,
  parameter int ADR_W = 12
) (
  input wire logic                    clk_sys,
  input wire logic                    reset,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire logic [2**(PID_W-1)-1:0] periph_req,
  input wire logic [2**(PID_W-1)-1:0] periph_ack,
  input wire dma_pkg::per_cmd_t       per_o,
  input wire dma_pkg::mem_cmd_t       mem_o,
  input wire dma_pkg::mem_rsp_t       mem_i
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // register bus: one answer a cycle after each request
  bus_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not answered in one cycle");
  ack_pulse_a: assert property (
    wb_ack_o |-> $past(wb_stb_i) ##1 !wb_ack_o)
    else $error("bus ack not a single answered pulse");
  idle_data_a: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data shown outside ack");
  // memory request holds its address until answered
  mem_hold_a: assert property (
    mem_o.req && !mem_i.ack && !mem_i.err |=>
      mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we))
    else $error("memory request changed before answer");
  // grants: one at a time, only to a requesting peripheral
  one_grant_a: assert property (
    $onehot0(periph_ack))
    else $error("more than one peripheral granted");
  grant_cause_a: assert property (
    periph_ack != 0 |-> ($past(periph_req) & periph_ack) != 0)
    else $error("grant without a request");
  // peripheral read turns into a memory write next cycle, memory read into a peripheral write
  read_to_mem_a: assert property (
    per_o.rd |=> mem_o.req && mem_o.we ##1 !per_o.rd)
    else $error("peripheral read not followed by memory write");
  read_to_per_a: assert property (
    mem_o.req && !mem_o.we && mem_i.ack |=> per_o.wr ##1 !per_o.wr)
    else $error("memory read not passed to the peripheral");
endmodule // dma_unit_chk

bind peripheral_dma_unit dma_unit_chk #(
  .N_CH(N_CH), .PID_W(PID_W), .ADR_W(ADR_W)
) chk_u (
  .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .periph_req(periph_req), .periph_ack(periph_ack), .per_o(per_o),
  .mem_o(mem_o), .mem_i(mem_i)
);

/* verif/testbench.sv */
// self-checking bench for the dma unit
`timescale 1ns/100ps
module testbench;
  import dma_pkg::*;
  localparam logic [5:0] o_ptr = 6'h00, o_sel = 6'h04, o_cnt = 6'h08;
  localparam logic [5:0] o_prl = 6'h0c, o_crl = 6'h10, o_ctl = 6'h14;
  localparam logic [5:0] o_mode = 6'h18, o_stat = 6'h1c, o_ien = 6'h20;
  localparam logic [5:0] o_idis = 6'h24, o_mask = 6'h28, o_flag = 6'h2c;
  logic        clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i, irq;
  logic [31:0] wb_dat_i, wb_dat_o, per_rdata, mem_last, per_last, rd_q;
  logic [7:0]  periph_req, periph_ack, want;
  logic [1:0]  lag;
  per_cmd_t    per_o;
  mem_cmd_t    mem_o;
  mem_rsp_t    mem_i;
  int          n_errors = 0, check_count = 0, cycles = 0, k;

  peripheral_dma_unit #(.N_CH(4), .PID_W(4), .ADR_W(12), .PSR_RST(8'h00))
  dut_u (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .periph_req(periph_req), .periph_ack(periph_ack),
    .per_o(per_o), .per_rdata(per_rdata), .mem_o(mem_o), .mem_i(mem_i),
    .irq(irq));
  dma_far_model far_u (.clk_sys(clk_sys), .reset(reset), .want(want),
    .lag(lag), .periph_req(periph_req), .periph_ack(periph_ack),
    .per_o(per_o), .per_rdata(per_rdata), .mem_o(mem_o), .mem_i(mem_i),
    .mem_wdata_q(mem_last), .per_wdata_q(per_last));

  // report counts and verdict, then stop
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one classic wishbone cycle, waits for ack; the hang guard bounds it
  task automatic wb(input logic w, input logic [5:0] ch, off,
                    input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {ch, off};
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] ch, off, input logic [31:0] d);
    wb(1'b1, ch, off, d);
  endtask
  task automatic cmp(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [5:0] ch, off, input logic [31:0] exp);
    wb(1'b0, ch, off, 32'h0);
    cmp(rd_q, exp);
  endtask
  // poll a register under a bound until it reads exp
  task automatic poll(input logic [5:0] ch, off, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      wb(1'b0, ch, off, 32'h0);
      n++;
    end while (rd_q !== exp && n < 60);
    cmp(rd_q, exp);
  endtask
  task automatic cfg(input logic [5:0] ch, input logic [31:0] s, m, p);
    wr(ch, o_sel, s);
    wr(ch, o_mode, m);
    wr(ch, o_ptr, p);
    wr(ch, o_ctl, 32'h1);
  endtask

  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  // main sequence
  initial begin
    {reset, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {wb_adr_i, wb_dat_i, want, lag} = '0;
    wb_sel_i = 4'hf;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    for (int o = 0; o < 44; o += 4) chk(6'd1, 6'(o), 32'h0);
    wr(6'd1, o_ptr, 32'h11);
    wr(6'd4, o_ptr, 32'h44);
    wr(6'd0, 6'h30, 32'h33);
    chk(6'd1, o_ptr, 32'h11);
    chk(6'd4, o_ptr, 32'h0);
    chk(6'd0, 6'h30, 32'h0);
    wr(6'd1, o_ien, 32'h7);
    wr(6'd1, o_idis, 32'h2);
    wr(6'd1, o_ien, 32'h0);
    chk(6'd1, o_mask, 32'h5);
    cmp(32'(irq[1]), 32'h1);
    wr(6'd1, o_idis, 32'h5);
    chk(6'd1, o_mask, 32'h0);
    cmp(32'(irq[1]), 32'h0);
    wr(6'd1, o_ctl, 32'h1);
    chk(6'd1, o_stat, 32'h1);
    wr(6'd1, o_ctl, 32'h3);
    chk(6'd1, o_stat, 32'h0);
    // each size, slow and quick memory, lane placement
    for (int s = 0; s < 3; s++) begin
      cfg(6'd0, 32'h0, 32'(s), 32'h200);
      want <= 8'h01;
      lag <= 2'(s);
      wr(6'd0, o_cnt, 32'h2);
      poll(6'd0, o_cnt, 32'h0);
      want <= 8'h00;
      chk(6'd0, o_ptr, 32'h200 + (2 << s));
      cmp(mem_last, (32'hdead_beef & (32'hffff_ffff >> (32 - (8 << s))))
        << (8 * ((1 << s) % 4)));
    end
    // double buffering
    cfg(6'd1, 32'h1, 32'h2, 32'h0);
    wr(6'd1, o_prl, 32'h400);
    wr(6'd1, o_crl, 32'h2);
    chk(6'd1, o_cnt, 32'h2);
    chk(6'd1, o_ptr, 32'h400);
    chk(6'd1, o_crl, 32'h0);
    wr(6'd1, o_prl, 32'h500);
    wr(6'd1, o_crl, 32'h1);
    chk(6'd1, o_flag, 32'h0);
    want <= 8'h02;
    poll(6'd1, o_crl, 32'h0);
    poll(6'd1, o_cnt, 32'h0);
    want <= 8'h00;
    chk(6'd1, o_ptr, 32'h504);
    chk(6'd1, o_prl, 32'h0);
    chk(6'd1, o_flag, 32'h3);
    // two channels asking at once
    cfg(6'd0, 32'h0, 32'h2, 32'h700);
    wr(6'd0, o_cnt, 32'h1);
    cfg(6'd2, 32'h2, 32'h2, 32'h800);
    wr(6'd2, o_cnt, 32'h1);
    want <= 8'h05;
    k = 0;
    while (periph_ack === 8'h00 && k < 40) begin
      @(posedge clk_sys);
      k++;
    end
    cmp(32'(periph_ack), 32'h1);
    poll(6'd2, o_cnt, 32'h0);
    want <= 8'h00;
    // memory fault on a memory-to-peripheral channel, then recovery
    cfg(6'd3, 32'hb, 32'h2, 32'hf000_0000);
    wr(6'd3, o_ien, 32'h4);
    want <= 8'h08;
    wr(6'd3, o_cnt, 32'h1);
    poll(6'd3, o_flag, 32'h5);
    cmp(32'(irq), 32'h8);
    chk(6'd3, o_cnt, 32'h1);
    wr(6'd3, o_ctl, 32'h0);
    chk(6'd3, o_flag, 32'h5);
    wr(6'd3, o_ptr, 32'h600);
    wr(6'd3, o_ctl, 32'h100);
    poll(6'd3, o_cnt, 32'h0);
    chk(6'd3, o_flag, 32'h3);
    cmp(per_last, 32'h0000_0600 ^ 32'h5a5a_5a5a);
    want <= 8'h00;
    finish_test();
  end
endmodule // testbench
